// ---- shared/frontend_gain_defines.vh ----
/*
 * register offsets, field positions, reset values and gain codes for the
 * front-end gain configuration slice.
 * assumes: included by bare name from the rtl files; definitions only.
 */
`ifndef FRONTEND_GAIN_DEFINES_VH
`define FRONTEND_GAIN_DEFINES_VH

// ============================================================
// register offsets (8-bit register address space)
`define OFS_SLOT_B_PULSE_COUNT_CFG  8'h36
`define OFS_SLOT_A_FRONTEND_MODE    8'h39
`define OFS_SLOT_A_GAIN_CONTROL     8'h42
`define OFS_SLOT_A_PATH_SELECT      8'h43
`define OFS_PER_CHANNEL_GAIN_SELECT 8'h55

// ============================================================
// reset values
`define RST_SLOT_B_PULSE_COUNT_CFG  16'h0818
`define RST_SLOT_A_FRONTEND_MODE    16'h22fc
`define RST_SLOT_A_GAIN_CONTROL     16'h1c38
`define RST_SLOT_A_PATH_SELECT      16'hada5
`define RST_PER_CHANNEL_GAIN_SELECT 16'h0000

// ============================================================
// field positions
`define PULSE_COUNT_MSB    15
`define PULSE_COUNT_LSB    8
`define PER_CH_EN_BIT      6
`define SHARED_GAIN_MSB    1
`define SHARED_GAIN_LSB    0
`define SLOT_A_PER_CH_MSB  5
`define SLOT_A_PER_CH_LSB  0
`define SLOT_B_PER_CH_MSB  11
`define SLOT_B_PER_CH_LSB  6

// ============================================================
// path connection words
`define PATH_FULL_ANALOG   16'hada5
`define PATH_TIA_ADC       16'hb065

// ============================================================
// gain codes and their resistance in kilo-ohm
`define GAIN_CODE_200K     2'h0
`define GAIN_CODE_100K     2'h1
`define GAIN_CODE_50K      2'h2
`define GAIN_CODE_25K      2'h3
`define KOHM_200           8'hc8
`define KOHM_100           8'h64
`define KOHM_50            8'h32
`define KOHM_25            8'h19

`endif

// ---- rtl/slot_gain_router.v ----
/*
 * routes one time slot's shared gain code and per-channel codes onto
 * the four channel gain codes; purely combinational.
 * assumes: inputs come from registers on the caller's clock.
 */
`timescale 1ns/1ns
`include "frontend_gain_defines.vh"

module slot_gain_router (
    // control
    input  wire       per_channel_enable,
    input  wire [1:0] shared_gain,
    // channels 2..4 codes, ch4 in [5:4], ch3 in [3:2], ch2 in [1:0]
    input  wire [5:0] per_channel_gains,
    // ch4 in [7:6] down to ch1 in [1:0]
    output reg  [7:0] channel_gains
);

// ============================================================
// routing
always @* begin
    if (per_channel_enable) begin
        channel_gains = {per_channel_gains, shared_gain};
    end else begin
        channel_gains = {shared_gain, shared_gain, shared_gain, shared_gain};
    end
end

endmodule // slot_gain_router

// ---- rtl/frontend_gain_config_regs.v ----
/*
 * configuration register slice: slot b pulse count, slot a front-end
 * mode and path words, and transimpedance gain selection for both slots.
 * assumes: the serial control interface decodes a register access into
 * one-cycle read/write strobes on core_clk; slot b's shared gain and
 * per-channel enable arrive from the neighbouring slot b register.
 */
// What this block does
// - slot b led pulse count in bits 15:8, resets to eight.
// - slot a enable set: ch1 from shared field, ch2-4 from bits 5:0.
// - slot a enable clear: shared gain code drives all four channels.
// - gain code 0..3 means 200,100,50,25 kohm; resets to code 0.
// - path word 0xada5 full analog, 0xb065 tia-to-adc; others illegal.
// - per-channel register holds slot b ch4,ch3,ch2 in 11:10,9:8,7:6.
// - per-channel register holds slot a ch4 in 5:4, ch3 in 3:2.
// - slot a ch2 gain sits in bits 1:0.
// - slot b enable routes ch1 shared, ch2-4 from bits 11:6.
`timescale 1ns/1ns
`include "frontend_gain_defines.vh"

module frontend_gain_config_regs (
    // clock and reset
    input  wire        core_clk,
    input  wire        rst_n,
    // register access from the serial control interface
    input  wire [7:0]  reg_addr,
    input  wire        reg_wr_en,
    input  wire [15:0] reg_wdata,
    input  wire        reg_rd_en,
    output reg  [15:0] reg_rdata_ff,
    output reg         reg_rd_hit_ff,
    // slot b fields held in the neighbouring register
    input  wire        slot_b_per_channel_gain_enable,
    input  wire [1:0]  slot_b_shared_gain,
    // configuration to the timing core and analog front end
    output reg  [7:0]  slot_b_led_pulse_count_ff,
    output reg  [15:0] slot_a_frontend_mode_word_ff,
    output reg  [15:0] slot_a_path_connection_ff,
    output reg         slot_a_path_tia_adc_ff,
    output reg         slot_a_path_illegal_ff,
    output reg  [7:0]  slot_a_channel_gains_ff,
    output reg  [7:0]  slot_b_channel_gains_ff,
    output reg  [7:0]  slot_a_ch1_kohm_ff,
    output reg  [7:0]  slot_b_ch1_kohm_ff
);

// ============================================================
// register storage
reg  [15:0] pulse_cfg_ff;
reg  [15:0] mode_ff;
reg  [15:0] gain_ctrl_ff;
reg  [15:0] path_ff;
reg  [15:0] per_ch_ff;
wire [7:0]  nxt_slot_a_gains;
wire [7:0]  nxt_slot_b_gains;
reg  [15:0] nxt_rdata;
reg         nxt_hit;

// gain code to resistance, used for both slots
function [7:0] gain_kohm;
    input [1:0] code;
    begin
        case (code)
            `GAIN_CODE_200K: gain_kohm = `KOHM_200;
            `GAIN_CODE_100K: gain_kohm = `KOHM_100;
            `GAIN_CODE_50K:  gain_kohm = `KOHM_50;
            `GAIN_CODE_25K:  gain_kohm = `KOHM_25;
            default:         gain_kohm = `KOHM_200;
        endcase
    end
endfunction

// ============================================================
// write strobes; unmapped writes raise none and are dropped
wire        wr_pulse_cfg;
wire        wr_mode;
wire        wr_gain_ctrl;
wire        wr_path;
wire        wr_per_ch;

assign wr_pulse_cfg = reg_wr_en && (reg_addr == `OFS_SLOT_B_PULSE_COUNT_CFG);
assign wr_mode      = reg_wr_en && (reg_addr == `OFS_SLOT_A_FRONTEND_MODE);
assign wr_gain_ctrl = reg_wr_en && (reg_addr == `OFS_SLOT_A_GAIN_CONTROL);
assign wr_path      = reg_wr_en && (reg_addr == `OFS_SLOT_A_PATH_SELECT);
assign wr_per_ch    = reg_wr_en && (reg_addr == `OFS_PER_CHANNEL_GAIN_SELECT);

// ============================================================
// registers: every bit stored, reserved ones too, so reads match
always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        pulse_cfg_ff <= `RST_SLOT_B_PULSE_COUNT_CFG;
    end else if (wr_pulse_cfg) begin
        pulse_cfg_ff <= reg_wdata;
    end
end

always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        mode_ff <= `RST_SLOT_A_FRONTEND_MODE;
    end else if (wr_mode) begin
        mode_ff <= reg_wdata;
    end
end

always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        gain_ctrl_ff <= `RST_SLOT_A_GAIN_CONTROL;
    end else if (wr_gain_ctrl) begin
        gain_ctrl_ff <= reg_wdata;
    end
end

always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        path_ff <= `RST_SLOT_A_PATH_SELECT;
    end else if (wr_path) begin
        path_ff <= reg_wdata;
    end
end

always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        per_ch_ff <= `RST_PER_CHANNEL_GAIN_SELECT;
    end else if (wr_per_ch) begin
        per_ch_ff <= reg_wdata;
    end
end

// ============================================================
// read mux; unmapped addresses read zero with hit low
always @* begin
    nxt_rdata = 16'h0000;
    nxt_hit   = 1'b1;
    case (reg_addr)
        `OFS_SLOT_B_PULSE_COUNT_CFG:  nxt_rdata = pulse_cfg_ff;
        `OFS_SLOT_A_FRONTEND_MODE:    nxt_rdata = mode_ff;
        `OFS_SLOT_A_GAIN_CONTROL:     nxt_rdata = gain_ctrl_ff;
        `OFS_SLOT_A_PATH_SELECT:      nxt_rdata = path_ff;
        `OFS_PER_CHANNEL_GAIN_SELECT: nxt_rdata = per_ch_ff;
        default:                      nxt_hit   = 1'b0;
    endcase
end

always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        reg_rdata_ff  <= 16'h0000;
        reg_rd_hit_ff <= 1'b0;
    end else if (reg_rd_en) begin
        reg_rdata_ff  <= nxt_rdata;
        reg_rd_hit_ff <= nxt_hit;
    end
end

// ============================================================
// gain routing per slot
slot_gain_router u_slot_a_router (
    .per_channel_enable (gain_ctrl_ff[`PER_CH_EN_BIT]),
    .shared_gain        (gain_ctrl_ff[`SHARED_GAIN_MSB:`SHARED_GAIN_LSB]),
    .per_channel_gains  (per_ch_ff[`SLOT_A_PER_CH_MSB:`SLOT_A_PER_CH_LSB]),
    .channel_gains      (nxt_slot_a_gains)
);

slot_gain_router u_slot_b_router (
    .per_channel_enable (slot_b_per_channel_gain_enable),
    .shared_gain        (slot_b_shared_gain),
    .per_channel_gains  (per_ch_ff[`SLOT_B_PER_CH_MSB:`SLOT_B_PER_CH_LSB]),
    .channel_gains      (nxt_slot_b_gains)
);

// ============================================================
// configuration outputs, one cycle behind the registers
always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        slot_b_led_pulse_count_ff <= 8'h00;
    end else begin
        slot_b_led_pulse_count_ff <= pulse_cfg_ff[`PULSE_COUNT_MSB:`PULSE_COUNT_LSB];
    end
end

always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        slot_a_frontend_mode_word_ff <= 16'h0000;
        slot_a_path_connection_ff    <= 16'h0000;
    end else begin
        slot_a_frontend_mode_word_ff <= mode_ff;
        slot_a_path_connection_ff    <= path_ff;
    end
end

// reserved words are passed on but flagged; the analog side decides
always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        slot_a_path_tia_adc_ff <= 1'b0;
    end else begin
        slot_a_path_tia_adc_ff <= (path_ff == `PATH_TIA_ADC);
    end
end

always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        slot_a_path_illegal_ff <= 1'b0;
    end else begin
        slot_a_path_illegal_ff <= (path_ff != `PATH_TIA_ADC) &&
                                  (path_ff != `PATH_FULL_ANALOG);
    end
end

// ch1 resistance decoded here so the analog side needs no table
always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        slot_a_channel_gains_ff <= 8'h00;
        slot_a_ch1_kohm_ff      <= 8'h00;
    end else begin
        slot_a_channel_gains_ff <= nxt_slot_a_gains;
        slot_a_ch1_kohm_ff      <= gain_kohm(nxt_slot_a_gains[1:0]);
    end
end

// slot b follows its input ports one edge later, like slot a its register
always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        slot_b_channel_gains_ff <= 8'h00;
        slot_b_ch1_kohm_ff      <= 8'h00;
    end else begin
        slot_b_channel_gains_ff <= nxt_slot_b_gains;
        slot_b_ch1_kohm_ff      <= gain_kohm(nxt_slot_b_gains[1:0]);
    end
end

endmodule // frontend_gain_config_regs

// ---- testbench/gain_regs_checker_assertions.sv ----
/* assertions on the gain configuration slice ports.
   assumes: one core_clk domain, rst_n asynchronous active low. */
`timescale 1ns/1ns
module gain_regs_checker (
    // clock, reset, register port
    input logic        core_clk,
    input logic        rst_n,
    input logic [7:0]  reg_addr,
    input logic        reg_wr_en,
    input logic [15:0] reg_wdata,
    input logic        reg_rd_en,
    input logic [15:0] reg_rdata_ff,
    input logic        reg_rd_hit_ff,
    // slot b inputs and configuration outputs
    input logic        slot_b_per_channel_gain_enable,
    input logic [1:0]  slot_b_shared_gain,
    input logic [7:0]  slot_b_led_pulse_count_ff,
    input logic        slot_a_path_tia_adc_ff,
    input logic        slot_a_path_illegal_ff,
    input logic [7:0]  slot_a_channel_gains_ff,
    input logic [7:0]  slot_b_channel_gains_ff,
    input logic [7:0]  slot_a_ch1_kohm_ff,
    input logic [7:0]  slot_b_ch1_kohm_ff
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // ========
    // writes show at the outputs two edges after the strobe
    chk_pulse_count:
        assert property (reg_wr_en && reg_addr == 8'h36 |=> ##1
            slot_b_led_pulse_count_ff == $past(reg_wdata[15:8], 2)) else $error("pulse count");
    chk_a_shared_gain:
        assert property (reg_wr_en && reg_addr == 8'h42 && !reg_wdata[6] |=> ##1
            slot_a_channel_gains_ff == {4{$past(reg_wdata[1:0], 2)}}) else $error("a shared");
    chk_a_ch1_gain:
        assert property (reg_wr_en && reg_addr == 8'h42 && reg_wdata[6] |=> ##1
            slot_a_channel_gains_ff[1:0] == $past(reg_wdata[1:0], 2)) else $error("a ch1");
    chk_path_decode:
        assert property (reg_wr_en && reg_addr == 8'h43 |=> ##1
            slot_a_path_tia_adc_ff == ($past(reg_wdata, 2) == 16'hb065) &&
            slot_a_path_illegal_ff == !($past(reg_wdata, 2) inside {16'hada5, 16'hb065}))
            else $error("path decode");
    // ========
    // $past(rst_n) skips the edge where outputs still hold reset zeros
    chk_b_shared_gain:
        assert property ($past(rst_n) && !$past(slot_b_per_channel_gain_enable) |->
            slot_b_channel_gains_ff == {4{$past(slot_b_shared_gain)}}) else $error("b shared");
    chk_b_ch1_gain:
        assert property ($past(rst_n) && $past(slot_b_per_channel_gain_enable) |->
            slot_b_channel_gains_ff[1:0] == $past(slot_b_shared_gain)) else $error("b ch1");
    chk_kohm_decode:
        assert property ($past(rst_n) |-> slot_a_ch1_kohm_ff == 8'hc8 >>
            slot_a_channel_gains_ff[1:0] && slot_b_ch1_kohm_ff == 8'hc8 >>
            slot_b_channel_gains_ff[1:0]) else $error("kohm decode");
    chk_read_hit:
        assert property (reg_rd_en && reg_addr inside {8'h36, 8'h39, 8'h42, 8'h43, 8'h55}
            |=> reg_rd_hit_ff) else $error("read hit");
    chk_unmapped_read:
        assert property (reg_rd_en && !(reg_addr inside {8'h36, 8'h39, 8'h42, 8'h43, 8'h55})
            |=> !reg_rd_hit_ff && reg_rdata_ff == 16'h0000) else $error("unmapped read");
endmodule // gain_regs_checker

bind frontend_gain_config_regs gain_regs_checker gain_regs_checker_inst (.*);

// ---- testbench/frontend_gain_config_regs_bench.sv ----
/* self-checking bench for the gain configuration slice.
   assumes: register strobes are one-cycle pulses on core_clk. */
`timescale 1ns/1ns
module frontend_gain_config_regs_bench;
    logic        core_clk = 0, rst_n = 0, reg_wr_en = 0, reg_rd_en = 0, b_en = 0;
    logic [7:0]  reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000, rdata, mode, path;
    logic [1:0]  b_gain = 2'h0;
    logic        hit, tia, bad;
    logic [7:0]  pulse, a_g, b_g, a_k, b_k;
    int          error_cnt = 0, checks_done = 0;
    frontend_gain_config_regs frontend_gain_config_regs_inst (.core_clk(core_clk),
        .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata),
        .reg_rd_en(reg_rd_en), .reg_rdata_ff(rdata), .reg_rd_hit_ff(hit),
        .slot_b_per_channel_gain_enable(b_en), .slot_b_shared_gain(b_gain),
        .slot_b_led_pulse_count_ff(pulse), .slot_a_frontend_mode_word_ff(mode),
        .slot_a_path_connection_ff(path), .slot_a_path_tia_adc_ff(tia),
        .slot_a_path_illegal_ff(bad), .slot_a_channel_gains_ff(a_g),
        .slot_b_channel_gains_ff(b_g), .slot_a_ch1_kohm_ff(a_k), .slot_b_ch1_kohm_ff(b_k));
    // ========
    // shared tasks
    task automatic chk(input logic [15:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_addr <= a; reg_wdata <= d; reg_wr_en <= 1'b1;
        @(posedge core_clk);
        reg_wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] exp, input logic h);
        @(posedge core_clk);
        reg_addr <= a; reg_rd_en <= 1'b1;
        @(posedge core_clk);
        reg_rd_en <= 1'b0;
        @(negedge core_clk);
        chk(rdata, exp);
        chk({15'h0000, hit}, {15'h0000, h});
    endtask
    // outputs follow one edge after the write edge
    task automatic settle; @(posedge core_clk); @(negedge core_clk); endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // ========
    // scenarios
    task automatic test_reset;
        settle;
        chk({pulse, a_k}, 16'h08c8);
        chk({a_g, 6'h00, tia, bad}, 16'h0000);
        rd(8'h36, 16'h0818, 1'b1);
        rd(8'h39, 16'h22fc, 1'b1);
        rd(8'h42, 16'h1c38, 1'b1);
        rd(8'h43, 16'hada5, 1'b1);
        rd(8'h55, 16'h0000, 1'b1);
        rd(8'h37, 16'h0000, 1'b0);
        $display("test_reset done");
    endtask
    task automatic test_rw;
        logic [7:0]  a [5] = '{8'h36, 8'h39, 8'h42, 8'h43, 8'h55};
        logic [15:0] d [5] = '{16'h1313, 16'h21f4, 16'h1c3b, 16'hb065, 16'hfe4d};
        for (int i = 0; i < 5; i++) wr(a[i], d[i]);
        wr(8'h54, 16'hffff);
        for (int i = 0; i < 5; i++) rd(a[i], d[i], 1'b1);
        chk({pulse, a_g}, 16'h13ff);
        chk(mode, 16'h21f4);
        chk({15'h0000, tia}, 16'h0001);
        $display("test_rw done");
    endtask
    task automatic test_gain;
        for (int c = 0; c < 4; c++) begin
            wr(8'h42, 16'h1c38 | c[15:0]);
            b_gain <= c[1:0];
            settle;
            chk({a_g, b_g}, {8{c[1:0]}});
            chk({a_k, b_k}, {2{8'hc8 >> c}});
        end
        wr(8'h55, 16'h0e46);
        b_en <= 1'b1;
        b_gain <= 2'h2;
        wr(8'h42, 16'h1c79);
        settle;
        chk({a_g, b_g}, 16'h19e6);
        wr(8'h42, 16'h1c3a);
        settle;
        chk(a_g, 8'haa);
        $display("test_gain done");
    endtask
    task automatic test_path;
        wr(8'h43, 16'h1234);
        settle;
        chk(path, 16'h1234);
        chk({14'h0000, tia, bad}, 16'h0001);
        wr(8'h43, 16'hb065);
        settle;
        chk({14'h0000, tia, bad}, 16'h0002);
        wr(8'h43, 16'hada5);
        settle;
        chk(path, 16'hada5);
        chk({14'h0000, tia, bad}, 16'h0000);
        $display("test_path done");
    endtask
    // ========
    initial forever #4 core_clk = ~core_clk;
    initial begin
        #200000;
        error_cnt++;
        wrap_up;
    end
    initial begin
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        test_reset;
        test_rw;
        test_gain;
        test_path;
        wrap_up;
    end
endmodule // frontend_gain_config_regs_bench
